// [hdl/scfg_defs.svh]
// constants for the configuration host: timings, mode codes, sizes
`ifndef SCFG_DEFS_SVH
`define SCFG_DEFS_SVH
`define SCFG_CLK_PERIOD_NS   10
`define SCFG_PROG_LOW_NS     300
`define SCFG_PROG_LOW_CYC    ((`SCFG_PROG_LOW_NS + `SCFG_CLK_PERIOD_NS - 1) / `SCFG_CLK_PERIOD_NS)
`define SCFG_CONFIG_CLOCK_HALF_CYC   8
`define SCFG_EXTRA_CLOCKS    64
`define SCFG_MODE_PARALLEL   3'h6
`define SCFG_MODE_SERIAL     3'h7
`define SCFG_FIFO_DEPTH      16
`define SCFG_DATA_W          8
`endif

// [hdl/scfg_pkg.sv]
// types for the configuration host
package scfg_pkg;
  typedef enum logic [2:0] {
    SCFG_IDLE, SCFG_PROG, SCFG_WAIT_INIT, SCFG_SEND, SCFG_STARTUP, SCFG_DONE, SCFG_ERROR
  } scfg_state_t;
  typedef struct packed {
    logic       running;
    logic       done;
    logic       error;
  } scfg_status_t;
  typedef struct packed {
    logic [7:0] data;
    logic       cs_n;
    logic       write_n;
  } scfg_par_t;
endpackage

// [hdl/scfg_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
module scfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q    <= cnt_d;
      // ready from a flop keeps the count compare off the upstream path
      in_ready <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  a_fifo_no_over: assert property (@(posedge mclk) disable iff (!rstn)
    cnt_q <= (AW+1)'(DEPTH) && (in_ready == (cnt_q != (AW+1)'(DEPTH))))
    else $error("fifo count above depth or ready out of step");
endmodule

// [hdl/scfg_host.sv]
// configuration host that loads a slave device in parallel or serial mode
// Notes on behaviour
// - program request low for 300 ns or more restarts configuration
// - host keeps program request high, may pulse it low to reprogram
// - parallel chain devices all get the parallel mode code
// - host holds write select low throughout parallel configuration
// - serial mode: data bit set up before rising configuration clock edge
// - host pulses program request, waits init high before data
// - host clocks data until completion high or init low; code stops with an error after 64 start-up clocks without completion
// - host gives extra clocks past the file for start-up
// - host holds mode pins defined when init rises
// - pull-up control low enables pull-ups, constant through configuration
// - host keeps chip select low for the whole parallel load
// - parallel mode: one byte per rising configuration clock edge
// - host holds the byte while busy is high
`include "scfg_defs.svh"
module scfg_host
  import scfg_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      start,
  input  wire logic                      serial_mode,
  input  wire logic                      pullup_off,
  input  wire logic [`SCFG_DATA_W-1:0]   s_data,
  input  wire logic                      s_valid,
  output logic                           s_ready,
  input  wire logic                      s_last,
  output logic                           program_request_n,
  output logic                           config_clock,
  output logic [`SCFG_DATA_W-1:0]        cfg_data,
  output logic                           cfg_cs_n,
  output logic                           write_select_n,
  output logic [2:0]                     mode_select,
  output logic                           pullup_disable,
  input  wire logic                      init_n_in,
  output logic                           init_n_out,
  output logic                           init_n_oe,
  input  wire logic                      done_in,
  output logic                           done_out,
  output logic                           done_oe,
  input  wire logic                      busy,
  output scfg_status_t                   status
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] init_sq;
  logic [1:0] done_sq;
  logic [1:0] busy_sq;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      init_sq <= 2'h0;
      done_sq <= 2'h0;
      busy_sq <= 2'h0;
    end else begin
      init_sq <= {init_sq[0], init_n_in};
      done_sq <= {done_sq[0], done_in};
      busy_sq <= {busy_sq[0], busy};
    end
  end
  logic init_hi;
  logic done_hi;
  logic busy_hi;
  assign init_hi = init_sq[1];
  assign done_hi = done_sq[1];
  assign busy_hi = busy_sq[1];

  // host never drives the open-drain status pins
  assign init_n_out = 1'b0;
  assign init_n_oe  = 1'b0;
  assign done_out   = 1'b0;
  assign done_oe    = 1'b0;

  // ---------------------------------------------------------------
  // data buffer
  // ---------------------------------------------------------------
  logic [8:0] f_data;
  logic       f_valid;
  logic       f_ready;
  scfg_fifo #(.WIDTH(9), .DEPTH(`SCFG_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_data   ({s_last, s_data}),
    .in_valid  (s_valid),
    .in_ready  (s_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  scfg_state_t state_q;
  logic [5:0]  prog_cnt_q;
  logic [3:0]  div_q;
  logic        rise;
  logic        fall;
  logic [2:0]  bit_q;
  logic        serial_q;
  logic        last_sent_q;
  logic [6:0]  extra_q;
  logic        have_q;
  logic [7:0]  shift_q;
  logic        init_low_seen_q;

  // clock edges are made at the end of each half period
  assign rise = (div_q == 4'(`SCFG_CONFIG_CLOCK_HALF_CYC - 1)) && !config_clock;
  assign fall = (div_q == 4'(`SCFG_CONFIG_CLOCK_HALF_CYC - 1)) && config_clock;
  // pop a byte when the slot is empty and we are on the low phase
  assign f_ready = (state_q == SCFG_SEND) && !have_q && !last_sent_q && !config_clock;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q           <= SCFG_IDLE;
      prog_cnt_q        <= 6'h0;
      program_request_n <= 1'b1;
      serial_q          <= 1'b0;
      extra_q           <= 7'h0;
      init_low_seen_q   <= 1'b0;
    end else begin
      case (state_q)
        SCFG_IDLE, SCFG_DONE, SCFG_ERROR: begin
          if (start) begin
            serial_q          <= serial_mode;
            program_request_n <= 1'b0;
            prog_cnt_q        <= 6'h0;
            init_low_seen_q   <= 1'b0;
            state_q           <= SCFG_PROG;
          end
        end
        SCFG_PROG: begin
          prog_cnt_q <= prog_cnt_q + 6'h1;
          if (prog_cnt_q == 6'(`SCFG_PROG_LOW_CYC)) begin
            program_request_n <= 1'b1;
            state_q           <= SCFG_WAIT_INIT;
          end
        end
        SCFG_WAIT_INIT: begin
          // a stale high from before the pulse must not count: wait for low, then high
          // limitation: a device that never shows init low keeps the host waiting here
          if (!init_hi) begin
            init_low_seen_q <= 1'b1;
          end else if (init_low_seen_q) begin
            state_q <= SCFG_SEND;
          end
        end
        SCFG_SEND: begin
          if (!init_hi) begin
            state_q <= SCFG_ERROR;
          end else if (done_hi) begin
            state_q <= SCFG_DONE;
          end else if (last_sent_q && !have_q) begin
            extra_q <= 7'h0;
            state_q <= SCFG_STARTUP;
          end
        end
        SCFG_STARTUP: begin
          if (!init_hi) begin
            state_q <= SCFG_ERROR;
          end else if (done_hi) begin
            state_q <= SCFG_DONE;
          end else if (rise && extra_q != 7'(`SCFG_EXTRA_CLOCKS)) begin
            extra_q <= extra_q + 7'h1;
          end else if (extra_q == 7'(`SCFG_EXTRA_CLOCKS)) begin
            state_q <= SCFG_ERROR;
          end
        end
        default: state_q <= SCFG_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration clock divider, only runs while loading
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_q        <= 4'h0;
      config_clock <= 1'b0;
    end else if (state_q == SCFG_SEND || state_q == SCFG_STARTUP) begin
      if (div_q == 4'(`SCFG_CONFIG_CLOCK_HALF_CYC - 1)) begin
        div_q <= 4'h0;
        // rising edge waits until the byte slot holds data or start-up clocks run
        if (config_clock || have_q || state_q == SCFG_STARTUP) begin
          config_clock <= !config_clock;
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end else begin
      div_q        <= 4'h0;
      config_clock <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // data path: byte per edge in parallel, msb first bit per edge serial
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      have_q      <= 1'b0;
      shift_q     <= 8'h00;
      bit_q       <= 3'h0;
      last_sent_q <= 1'b0;
      cfg_data    <= 8'h00;
    end else if (state_q == SCFG_PROG) begin
      have_q      <= 1'b0;
      bit_q       <= 3'h0;
      last_sent_q <= 1'b0;
    end else if (f_valid && f_ready) begin
      have_q      <= 1'b1;
      shift_q     <= f_data[7:0];
      last_sent_q <= f_data[8];
      bit_q       <= 3'h0;
      cfg_data    <= serial_q ? {7'h00, f_data[7]} : f_data[7:0];
    end else if (fall && have_q && !(busy_hi && !serial_q)) begin
      // busy seen after a rise keeps the byte for another cycle
      if (!serial_q || bit_q == 3'h7) begin
        have_q <= 1'b0;
      end else begin
        bit_q    <= bit_q + 3'h1;
        shift_q  <= {shift_q[6:0], 1'b0};
        cfg_data <= {7'h00, shift_q[6]};
      end
    end
  end

  // ---------------------------------------------------------------
  // static pins and status
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_cs_n       <= 1'b1;
      write_select_n <= 1'b1;
      mode_select    <= `SCFG_MODE_PARALLEL;
      pullup_disable <= 1'b0;
      status         <= '0;
    end else begin
      if (state_q == SCFG_IDLE || state_q == SCFG_DONE || state_q == SCFG_ERROR) begin
        pullup_disable <= pullup_off;
        // mode pins stay put from program pulse through init rise
        mode_select <= serial_mode ? `SCFG_MODE_SERIAL : `SCFG_MODE_PARALLEL;
      end
      cfg_cs_n       <= !(state_q == SCFG_SEND || state_q == SCFG_STARTUP) || serial_q;
      write_select_n <= !(state_q != SCFG_IDLE) || serial_q;
      status.running <= state_q != SCFG_IDLE && state_q != SCFG_DONE && state_q != SCFG_ERROR;
      status.done    <= state_q == SCFG_DONE;
      status.error   <= state_q == SCFG_ERROR;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_prog_pulse;
    $fell(program_request_n) ##1 (!program_request_n) [*8];
  endsequence
  a_prog_width: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(program_request_n) |-> s_prog_pulse) else $error("program pulse too short");
  a_pull_steady: assert property (@(posedge mclk) disable iff (!rstn)
    status.running && $past(status.running) |-> $stable(pullup_disable))
    else $error("pull-up control moved while loading");
  a_mode_steady: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == SCFG_WAIT_INIT |-> $stable(mode_select)) else $error("mode moved before init");
  a_write_low: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == SCFG_SEND && !serial_q |=> !write_select_n) else $error("write select high");
  a_cs_low: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == SCFG_SEND && !serial_q |=> !cfg_cs_n) else $error("chip select high");
  a_data_stable: assert property (@(posedge mclk) disable iff (!rstn)
    rise && have_q |=> $stable(cfg_data)) else $error("data moved on rising clock");
  a_busy_hold: assert property (@(posedge mclk) disable iff (!rstn)
    fall && have_q && busy_hi && !serial_q |=> have_q) else $error("byte dropped while busy");
  a_no_early: assert property (@(posedge mclk) disable iff (!rstn)
    state_q == SCFG_WAIT_INIT |-> !config_clock) else $error("clock before init high");
endmodule

// [tb/scfg_dev_model.sv]
// behavioural model of the slave device behind the configuration host
module scfg_dev_model (
  input  wire logic        mclk,
  input  wire logic        program_request_n,
  input  wire logic        config_clock,
  input  wire logic [7:0]  cfg_data,
  input  wire logic        cfg_cs_n,
  input  wire logic        write_select_n,
  input  wire logic [2:0]  mode_select,
  input  wire logic        pullup_disable,
  input  wire logic [15:0] file_len,
  input  wire logic [7:0]  clear_len,
  input  wire logic        crc_fail,
  input  wire logic        busy_en,
  output logic             init_low,
  output logic             done_low,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PROG_MIN = 30;  // 300 ns at the 10 ns clock
  logic [7:0] rx_q[$];
  logic [7:0] sh_q;
  logic [2:0] mode_q;
  logic       pu_q = 0;
  logic       ck_q = 0;
  logic       on_q = 0;
  int         prog_q = 0;
  int         clr_q = 0;
  int         bit_q = 0;
  int         su_q = 0;
  int         viol = 0;
  initial begin
    init_low = 1'b0;
    done_low = 1'b1;
    busy = 1'b0;
  end
  // -----------------------------------------------------------
  // pins are open-drain: the low flags pull, the bench adds pull-ups
  // -----------------------------------------------------------
  always @(posedge mclk) begin
    ck_q <= config_clock;
    prog_q <= program_request_n ? 0 : prog_q + 1;
    if (program_request_n && prog_q >= PROG_MIN) begin
      init_low <= 1'b1;
      done_low <= 1'b1;
      on_q <= 1'b0;
      clr_q <= clear_len + 1;
      bit_q <= 0;
      su_q <= 0;
      busy <= 1'b0;
      rx_q.delete();
    end else if (clr_q > 1) begin
      clr_q <= clr_q - 1;
      if (config_clock && !ck_q) viol <= viol + 1;
    end else if (clr_q == 1) begin
      clr_q <= 0;
      init_low <= 1'b0;
      mode_q <= mode_select;
      pu_q <= pullup_disable;
      on_q <= 1'b1;
    end else if (on_q && config_clock && !ck_q) begin
      if (pu_q !== pullup_disable) viol <= viol + 1;
      if (rx_q.size() >= file_len) begin
        su_q <= su_q + 1;
        if (su_q == 7) begin
          done_low <= 1'b0;
          on_q <= 1'b0;
        end
      end else if (mode_q == 3'h7) begin
        sh_q <= {sh_q[6:0], cfg_data[0]};
        bit_q <= bit_q + 1;
        if (bit_q % 8 == 7) rx_q.push_back({sh_q[6:0], cfg_data[0]});
      end else if (busy) begin
        busy <= 1'b0;
      end else begin
        if (cfg_cs_n || write_select_n) viol <= viol + 1;
        rx_q.push_back(cfg_data);
        busy <= busy_en && ($urandom_range(3) == 0);
      end
    end
    if (on_q && crc_fail && rx_q.size() >= file_len) begin
      init_low <= 1'b1;
      on_q <= 1'b0;
    end
  end
endmodule

// [tb/tb_scfg_host.sv]
// self-checking bench for the configuration host
`include "scfg_defs.svh"
module tb_scfg_host
  import scfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         mclk = 0, rstn = 0, start = 0, serial_mode = 0, pullup_off = 0;
  logic [7:0]   s_data = '0, cfg_data, clear_len = 8'h10;
  logic         s_valid = 0, s_last = 0, s_ready, program_request_n, config_clock;
  logic         cfg_cs_n, write_select_n, pullup_disable, busy, init_low, done_low;
  logic         init_n_out, init_n_oe, done_out, done_oe, crc_fail = 0, busy_en = 0;
  logic [2:0]   mode_select;
  logic [15:0]  file_len = 16'h0010;
  scfg_status_t status;
  int           mismatches = 0, check_count = 0, plow = 0, last_plow = 0, wait_cnt;
  logic [7:0]   tx_q[$];
  wire          init_line = ~(init_low | (init_n_oe & ~init_n_out));
  wire          done_line = ~(done_low | (done_oe & ~done_out));

  scfg_host i_scfg_host (.mclk, .rstn, .start, .serial_mode, .pullup_off, .s_data,
    .s_valid, .s_ready, .s_last, .program_request_n, .config_clock, .cfg_data, .cfg_cs_n,
    .write_select_n, .mode_select, .pullup_disable, .init_n_in(init_line), .init_n_out,
    .init_n_oe, .done_in(done_line), .done_out, .done_oe, .busy, .status);
  scfg_dev_model i_scfg_dev_model (.mclk, .program_request_n, .config_clock, .cfg_data,
    .cfg_cs_n, .write_select_n, .mode_select, .pullup_disable, .file_len, .clear_len,
    .crc_fail, .busy_en, .init_low, .done_low, .busy);

  always #5 mclk = ~mclk;

  // width of the last program request pulse, in clock cycles
  always @(posedge mclk) begin
    if (program_request_n === 1'b0) plow <= plow + 1;
    else if (plow != 0) begin
      last_plow <= plow;
      plow <= 0;
    end
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      mismatches++;
    end
  endtask

  function automatic logic [2:0] exp_mode(bit ser);
    return ser ? `SCFG_MODE_SERIAL : `SCFG_MODE_PARALLEL;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // -----------------------------------------------------------
  // one full load: prefill the fifo to refusal, start, stream the rest
  // -----------------------------------------------------------
  task automatic run_load(bit ser, bit crc, bit bsy, int n);
    int   acc;
    int   tog;
    logic prv;
    tx_q.delete();
    for (int i = 0; i < n; i++) tx_q.push_back(8'($urandom));
    serial_mode <= ser;
    crc_fail <= crc;
    busy_en <= bsy;
    file_len <= 16'(n);
    clear_len <= 8'($urandom_range(5, 200));
    acc = 0;
    s_valid <= 1'b1;
    s_data <= tx_q[0];
    repeat (24) begin
      @(posedge mclk);
      if (s_ready === 1'b1) begin
        acc++;
        s_data <= tx_q[acc];
      end
    end
    check("fifo_fill", `SCFG_FIFO_DEPTH, acc);
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int i = acc; i < n; i++) begin
      // random gaps of 1 to 40 cycles drop valid; the fifo, kept full, keeps the host fed through them
      if (i > acc && $urandom_range(3) == 0) begin
        s_valid <= 1'b0;
        repeat ($urandom_range(1, 40)) @(posedge mclk);
      end
      s_data <= tx_q[i];
      s_valid <= 1'b1;
      s_last <= (i == n - 1);
      wait_cnt = 0;
      do begin
        @(posedge mclk);
        wait_cnt++;
      end while (s_ready !== 1'b1 && wait_cnt < 5000);
      check("stream_stall", 1, wait_cnt < 5000);
    end
    check("status_running", 1, status.running);
    s_valid <= 1'b0;
    s_last <= 1'b0;
    wait_cnt = 0;
    while (status.done !== 1'b1 && status.error !== 1'b1 && wait_cnt < 30000) begin
      @(posedge mclk);
      wait_cnt++;
    end
    check("prog_low_long", 1, last_plow >= `SCFG_PROG_LOW_CYC);
    check("mode_sampled", exp_mode(ser), i_scfg_dev_model.mode_q);
    check("status_done", !crc, status.done);
    check("status_error", crc, status.error);
    check("status_idle", 0, status.running);
    check("host_faults", 0, i_scfg_dev_model.viol);
    for (int i = 0; i < n && !crc; i++)
      check("rx_byte", tx_q[i], i_scfg_dev_model.rx_q[i]);
    tog = 0;
    prv = config_clock;
    repeat (100) begin
      @(negedge mclk);
      if (config_clock !== prv) tog++;
      prv = config_clock;
    end
    check("clock_stopped", 0, tog);
  endtask

  initial begin
    void'($urandom(32'h0000_dece));
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check("prog_idle", 1, program_request_n);
    check("cs_idle", 1, cfg_cs_n);
    check("mode_idle", exp_mode(0), mode_select);
    for (int p = 0; p < 2; p++) begin
      pullup_off <= p[0];
      repeat (3) @(posedge mclk);
      check("pullup_idle", p, pullup_disable);
    end
    run_load(0, 0, 1, 24);
    run_load(1, 0, 0, 20);
    run_load(0, 1, 1, 18);
    run_load(1, 1, 0, 18);
    run_load(0, 0, 1, 40);
    end_of_test();
  end

  initial begin
    #600_000;
    mismatches++;
    end_of_test();
  end
endmodule
